// file: verilog/dios_top.v
// Drive relay, fan, link supervision and input conditioning logic
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/100ps
`include "dios_defs.vh"

module dios_top #(
    parameter TICK_CYCLES = `DIOS_TICK_CYCLES // Cycles per 1 ms tick
) (
    input wire CLOCK, // 200 MHz clock
    input wire RSTN, // Synchronous reset, active low
    input wire PSEL, // APB select
    input wire PENABLE, // APB enable
    input wire PWRITE, // APB direction
    input wire [7:0] PADDR, // APB byte address
    input wire [31:0] PWDATA, // APB write data
    output wire PREADY, // APB ready
    output reg [31:0] PRDATA, // APB read data
    output wire PSLVERR, // APB error on unmapped address
    input wire TRIP, // Drive tripped, level
    input wire RUNNING, // Drive running, level
    input wire [7:0] TEMP_C, // Drive temperature in Celsius
    input wire [15:0] SPEED_IN, // Present output speed
    input wire [10:0] RAW_INPUTS, // Digital input pins
    input wire FRAME_VALID, // Good frame received, pulse
    input wire [7:0] FRAME_ADDR, // Station field of that frame
    input wire TX_REQ, // Reply ready to send, pulse
    output reg FRAME_ACCEPT, // Frame is ours, pulse
    output reg TX_START, // Start sending reply, pulse
    output reg FAULT_RELAY, // Fault relay closed
    output reg FAN_ON, // Cooling fan on
    output reg CLEAN_RELAY, // Screen-clean aux relay closed
    output reg LINK_LOSS_FAULT, // Remote link loss fault
    output reg HOLD_ACTIVE, // Run at held speed
    output reg COAST_STOP, // Stop output, coast
    output reg DECEL_STOP, // Ramp down on decel time
    output reg [15:0] SPEED_HOLD, // Speed captured before loss
    output reg [1:0] TEST_LEVEL, // Test output level code
    output reg [10:0] INPUTS, // Conditioned inputs
    output reg SECOND_SET, // Second parameter set in use
    output reg SECOND_GAIN // Second loop gain in use
);

// ----------------------------------------
// Helpers
// ----------------------------------------
function pick;
    input [10:0] vec;
    input [3:0] idx;
    begin
        pick = (idx < 4'hb) ? vec[idx] : 1'b0;
    end
endfunction

// ----------------------------------------
// Registers
// ----------------------------------------
reg [31:0] ctrl_r;
reg [31:0] flt_dly_r;
reg [31:0] fan_temp_r;
reg [31:0] clean_r;
reg [31:0] comm_r;
reg [10:0] pol_r;
reg test_go_r;
reg [31:0] rdata_nxt;

wire acc = PSEL && PENABLE;
wire wr = acc && PWRITE;
reg hit;

assign PREADY = 1'b1;
assign PSLVERR = acc && !hit;

always @* begin
    hit = 1'b1;
    rdata_nxt = 32'h0000_0000;
    case (PADDR)
        `DIOS_CTRL: rdata_nxt = ctrl_r & ~(32'h1 << `DIOS_F_TEST);
        `DIOS_FLT_DLY: rdata_nxt = flt_dly_r;
        `DIOS_FAN_TEMP: rdata_nxt = fan_temp_r;
        `DIOS_CLEAN: rdata_nxt = clean_r;
        `DIOS_COMM: rdata_nxt = comm_r;
        `DIOS_POLARITY: rdata_nxt = {21'h0, pol_r};
        `DIOS_STATUS: rdata_nxt = {5'h0, INPUTS, 5'h0, SECOND_GAIN, SECOND_SET, TEST_LEVEL,
            COAST_STOP, DECEL_STOP, HOLD_ACTIVE, LINK_LOSS_FAULT, CLEAN_RELAY, FAN_ON,
            FAULT_RELAY};
        `DIOS_HOLD: rdata_nxt = {16'h0, SPEED_HOLD};
        default: hit = 1'b0;
    endcase
end

// Read data is caught in the setup cycle, so it comes from a flop yet stands all access long
always @(posedge CLOCK) begin
    if (!RSTN) begin
        PRDATA <= 32'h0000_0000;
    end else if (PSEL && !PENABLE) begin
        PRDATA <= rdata_nxt;
    end
end

always @(posedge CLOCK) begin
    if (!RSTN) begin
        ctrl_r <= `DIOS_CTRL_RST;
        flt_dly_r <= `DIOS_FLT_DLY_RST;
        fan_temp_r <= `DIOS_FAN_TEMP_RST;
        clean_r <= `DIOS_CLEAN_RST;
        comm_r <= `DIOS_COMM_RST;
        pol_r <= `DIOS_POL_RST;
        test_go_r <= 1'b0;
    end else begin
        test_go_r <= wr && (PADDR == `DIOS_CTRL) && PWDATA[`DIOS_F_TEST];
        if (wr) begin
            case (PADDR)
                `DIOS_CTRL: ctrl_r <= PWDATA;
                `DIOS_FLT_DLY: flt_dly_r <= PWDATA;
                `DIOS_FAN_TEMP: fan_temp_r <= PWDATA;
                `DIOS_CLEAN: clean_r <= PWDATA;
                `DIOS_COMM: comm_r <= PWDATA;
                `DIOS_POLARITY: pol_r <= PWDATA[10:0];
                default: ;
            endcase
        end
    end
end

wire [1:0] fan_mode = ctrl_r[`DIOS_F_FAN_LO+1:`DIOS_F_FAN_LO];
wire [1:0] react = ctrl_r[`DIOS_F_REACT_LO+1:`DIOS_F_REACT_LO];
wire [3:0] sel2 = ctrl_r[`DIOS_F_SEL2_LO+3:`DIOS_F_SEL2_LO];
wire [3:0] gsel = ctrl_r[`DIOS_F_GSEL_LO+3:`DIOS_F_GSEL_LO];
wire [7:0] station = comm_r[7:0];
wire [15:0] timeout_ms = comm_r[23:8];
wire [7:0] resp_ms = comm_r[31:24];

// ----------------------------------------
// Millisecond and second ticks
// ----------------------------------------
// Long delays run off slow ticks so every counter stays narrow
localparam MS_LAST = `DIOS_MS_PER_S - 1;
reg [17:0] div_r;
reg [9:0] ms_r;
reg tick_ms, tick_s;

always @(posedge CLOCK) begin
    if (!RSTN) begin
        div_r <= 18'h0;
        ms_r <= 10'h0;
        tick_ms <= 1'b0;
        tick_s <= 1'b0;
    end else begin
        tick_ms <= 1'b0;
        tick_s <= 1'b0;
        if (div_r == TICK_CYCLES[17:0] - 18'h1) begin
            div_r <= 18'h0;
            tick_ms <= 1'b1;
            if (ms_r == MS_LAST[9:0]) begin
                ms_r <= 10'h0;
                tick_s <= 1'b1;
            end else begin
                ms_r <= ms_r + 10'h1;
            end
        end else begin
            div_r <= div_r + 18'h1;
        end
    end
end

// ----------------------------------------
// Input conditioning
// ----------------------------------------
reg [10:0] in_m_r, in_s_r;

always @(posedge CLOCK) begin
    if (!RSTN) begin
        in_m_r <= 11'h0;
        in_s_r <= 11'h0;
        INPUTS <= 11'h0;
        SECOND_SET <= 1'b0;
        SECOND_GAIN <= 1'b0;
    end else begin
        in_m_r <= RAW_INPUTS;
        in_s_r <= in_m_r;
        INPUTS <= in_s_r ^ pol_r;
        SECOND_SET <= pick(INPUTS, sel2);
        SECOND_GAIN <= pick(INPUTS, gsel);
    end
end

// ----------------------------------------
// Fault relay and fan
// ----------------------------------------
localparam FR_IDLE = 2'h0;
localparam FR_ON_WAIT = 2'h1;
localparam FR_ACTIVE = 2'h2;
localparam FR_OFF_WAIT = 2'h3;
reg [1:0] fr_st;
reg [7:0] fr_cnt;

always @(posedge CLOCK) begin
    if (!RSTN) begin
        fr_st <= FR_IDLE;
        fr_cnt <= 8'h0;
        FAULT_RELAY <= 1'b0;
        FAN_ON <= 1'b0;
    end else begin
        case (fan_mode)
            `DIOS_FAN_RUN: FAN_ON <= RUNNING;
            `DIOS_FAN_TEMP_M: FAN_ON <= (TEMP_C > fan_temp_r[7:0]);
            default: FAN_ON <= 1'b1;
        endcase
        case (fr_st)
            FR_IDLE: begin
                fr_cnt <= flt_dly_r[7:0];
                if (TRIP) fr_st <= FR_ON_WAIT;
            end
            FR_ON_WAIT: begin
                if (!TRIP) begin
                    fr_st <= FR_IDLE;
                end else if (fr_cnt == 8'h0) begin
                    fr_st <= FR_ACTIVE;
                    FAULT_RELAY <= 1'b1;
                end else if (tick_s) begin
                    fr_cnt <= fr_cnt - 8'h1;
                end
            end
            FR_ACTIVE: begin
                fr_cnt <= flt_dly_r[15:8];
                if (!TRIP) fr_st <= FR_OFF_WAIT;
            end
            FR_OFF_WAIT: begin
                if (TRIP) begin
                    fr_st <= FR_ACTIVE;
                end else if (fr_cnt == 8'h0) begin
                    fr_st <= FR_IDLE;
                    FAULT_RELAY <= 1'b0;
                end else if (tick_s) begin
                    fr_cnt <= fr_cnt - 8'h1;
                end
            end
            default: fr_st <= FR_IDLE;
        endcase
    end
end

// ----------------------------------------
// Screen clean cycling
// ----------------------------------------
localparam SC_IDLE = 2'h0;
localparam SC_FIRST = 2'h1;
localparam SC_CLEAN = 2'h2;
localparam SC_GAP = 2'h3;
localparam SC_FIRST_LOAD = `DIOS_CLEAN_FIRST_S - 1;
reg [1:0] sc_st;
reg [15:0] sc_cnt;

always @(posedge CLOCK) begin
    if (!RSTN) begin
        sc_st <= SC_IDLE;
        sc_cnt <= 16'h0;
        CLEAN_RELAY <= 1'b0;
    end else if (!RUNNING || !ctrl_r[`DIOS_F_CLEAN_EN]) begin
        sc_st <= SC_IDLE;
        CLEAN_RELAY <= 1'b0;
    end else begin
        case (sc_st)
            SC_IDLE: begin
                sc_st <= SC_FIRST;
                sc_cnt <= SC_FIRST_LOAD[15:0];
            end
            SC_FIRST, SC_GAP: begin
                if (sc_cnt == 16'h0 && tick_s) begin
                    sc_st <= SC_CLEAN;
                    sc_cnt <= clean_r[31:16] - 16'h1;
                    CLEAN_RELAY <= 1'b1;
                end else if (tick_s) begin
                    sc_cnt <= sc_cnt - 16'h1;
                end
            end
            SC_CLEAN: begin
                if (sc_cnt == 16'h0 && tick_s) begin
                    sc_st <= SC_GAP;
                    sc_cnt <= clean_r[15:0] - 16'h1;
                    CLEAN_RELAY <= 1'b0;
                end else if (tick_s) begin
                    sc_cnt <= sc_cnt - 16'h1;
                end
            end
            default: sc_st <= SC_IDLE;
        endcase
    end
end

// ----------------------------------------
// Link supervision and reply delay
// ----------------------------------------
reg [15:0] silence_ms;
reg [15:0] spd_1s, spd_2s;
reg [8:0] resp_cnt;
reg resp_pend;
wire ours = FRAME_VALID && (FRAME_ADDR == station);
// only when the link commands the drive
wire supervise = ctrl_r[`DIOS_F_RUN485] || ctrl_r[`DIOS_F_FREQ485];

always @(posedge CLOCK) begin
    if (!RSTN) begin
        silence_ms <= 16'h0;
        spd_1s <= 16'h0;
        spd_2s <= 16'h0;
        SPEED_HOLD <= 16'h0;
        LINK_LOSS_FAULT <= 1'b0;
        HOLD_ACTIVE <= 1'b0;
        COAST_STOP <= 1'b0;
        DECEL_STOP <= 1'b0;
        FRAME_ACCEPT <= 1'b0;
        TX_START <= 1'b0;
        resp_cnt <= 9'h0;
        resp_pend <= 1'b0;
    end else begin
        FRAME_ACCEPT <= ours;
        TX_START <= 1'b0;
        // speed history, one sample per second
        if (tick_s) begin
            spd_1s <= SPEED_IN;
            spd_2s <= spd_1s;
        end
        if (ours || !supervise) begin
            silence_ms <= 16'h0;
        end else if (tick_ms && silence_ms != 16'hffff) begin
            silence_ms <= silence_ms + 16'h1;
        end
        if (ours || !supervise) begin
            LINK_LOSS_FAULT <= 1'b0;
            HOLD_ACTIVE <= 1'b0;
            COAST_STOP <= 1'b0;
            DECEL_STOP <= 1'b0;
        end else if (!LINK_LOSS_FAULT && silence_ms > timeout_ms) begin
            LINK_LOSS_FAULT <= 1'b1;
            SPEED_HOLD <= spd_2s;
            HOLD_ACTIVE <= (react == `DIOS_REACT_HOLD);
            COAST_STOP <= (react == `DIOS_REACT_COAST);
            DECEL_STOP <= (react == `DIOS_REACT_DECEL);
        end
        // response delay, one extra tick so it is never short
        if (TX_REQ) begin
            resp_pend <= 1'b1;
            resp_cnt <= {1'b0, resp_ms} + 9'h1;
        end else if (resp_pend && resp_cnt == 9'h0) begin
            resp_pend <= 1'b0;
            TX_START <= 1'b1;
        end else if (resp_pend && tick_ms) begin
            resp_cnt <= resp_cnt - 9'h1;
        end
    end
end

// ----------------------------------------
// Analog test output sequence
// ----------------------------------------
localparam TST_LOAD = `DIOS_TEST_STEP_S - 1;
reg [2:0] tst_step;
reg [4:0] tst_cnt;

always @(posedge CLOCK) begin
    if (!RSTN) begin
        tst_step <= 3'h0;
        tst_cnt <= 5'h0;
        TEST_LEVEL <= `DIOS_LVL_OFF;
    end else if (test_go_r) begin
        // start (or restart) four 15 s steps
        tst_step <= 3'h1;
        tst_cnt <= TST_LOAD[4:0];
        TEST_LEVEL <= `DIOS_LVL_3V;
    end else if (tst_step != 3'h0 && tick_s) begin
        if (tst_cnt != 5'h0) begin
            tst_cnt <= tst_cnt - 5'h1;
        end else if (tst_step == 3'h4) begin
            tst_step <= 3'h0;
            TEST_LEVEL <= `DIOS_LVL_OFF;
        end else begin
            tst_step <= tst_step + 3'h1;
            tst_cnt <= TST_LOAD[4:0];
            TEST_LEVEL <= tst_step[0] ? `DIOS_LVL_4V7 : `DIOS_LVL_3V;
        end
    end
end

endmodule // dios_top

// file: verilog/dios_defs.vh
// Register offsets, field positions, reset values and timing constants
`ifndef DIOS_DEFS_VH
`define DIOS_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DIOS_CTRL 8'h00
`define DIOS_FLT_DLY 8'h04
`define DIOS_FAN_TEMP 8'h08
`define DIOS_CLEAN 8'h0c
`define DIOS_COMM 8'h10
`define DIOS_POLARITY 8'h14
`define DIOS_STATUS 8'h18
`define DIOS_HOLD 8'h1c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define DIOS_F_FAN_LO 0
`define DIOS_F_REACT_LO 2
`define DIOS_F_RUN485 4
`define DIOS_F_FREQ485 5
`define DIOS_F_TEST 8
`define DIOS_F_CLEAN_EN 9
`define DIOS_F_SEL2_LO 16
`define DIOS_F_GSEL_LO 20

// ----------------------------------------
// Modes
// ----------------------------------------
`define DIOS_FAN_POWER 2'h0
`define DIOS_FAN_RUN 2'h1
`define DIOS_FAN_TEMP_M 2'h2
`define DIOS_REACT_HOLD 2'h0
`define DIOS_REACT_COAST 2'h1
`define DIOS_REACT_DECEL 2'h2
`define DIOS_LVL_OFF 2'h0
`define DIOS_LVL_3V 2'h1
`define DIOS_LVL_4V7 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DIOS_CTRL_RST 32'h00ff_0000
`define DIOS_FLT_DLY_RST 32'h0000_0000
`define DIOS_FAN_TEMP_RST 32'h0000_0046
`define DIOS_CLEAN_RST 32'h003c_2a30
`define DIOS_COMM_RST 32'h0503_e801
`define DIOS_POL_RST 11'h000

// ----------------------------------------
// Timing
// ----------------------------------------
`define DIOS_CLK_HZ 200000000
`define DIOS_TICK_MS 1
`define DIOS_TICK_CYCLES (`DIOS_CLK_HZ / 1000 * `DIOS_TICK_MS)
`define DIOS_MS_PER_S 1000
`define DIOS_CLEAN_FIRST_S 180
`define DIOS_TEST_STEP_S 15
`define DIOS_HOLD_BACK_S 2

`endif

// file: verification/dios_net_master.sv
// Serial network master model: sends station frames and asks for replies
`timescale 1ns/100ps
module dios_net_master (
    input wire logic clk, // Bench clock
    input wire logic frame_accept, // Frame taken by the block
    input wire logic tx_start, // Block begins its reply
    output logic frame_valid, // Good frame strobe
    output logic [7:0] frame_addr, // Station field of the frame
    output logic tx_req // Reply request strobe
);
    initial begin
        frame_valid = 1'b0;
        frame_addr = 8'h5a;
        tx_req = 1'b0;
    end

    // Station field only means something beside the strobe, so it is scrambled after
    task send_frame(input logic [7:0] addr, output logic acc);
        @(posedge clk);
        frame_valid <= 1'b1;
        frame_addr <= addr;
        @(posedge clk);
        frame_valid <= 1'b0;
        frame_addr <= ~addr;
        // The accept pulse is registered, so it is seen one edge after the strobe
        @(posedge clk);
        acc = frame_accept;
    endtask

    task ask_reply(output int waited);
        @(posedge clk);
        tx_req <= 1'b1;
        @(posedge clk);
        tx_req <= 1'b0;
        waited = 0;
        while (tx_start !== 1'b1 && waited < 1000) begin
            @(posedge clk);
            waited = waited + 1;
        end
    endtask
endmodule // dios_net_master

// file: verification/dios_props.sv
// Concurrent checks on the ports of the supervision block
`timescale 1ns/100ps
module dios_props (
    input wire CLOCK, // Clock
    input wire RSTN, // Reset, active low
    input wire PSEL, // APB select
    input wire PENABLE, // APB enable
    input wire PWRITE, // APB direction
    input wire [7:0] PADDR, // APB address
    input wire [31:0] PWDATA, // APB write data
    input wire [31:0] PRDATA, // APB read data
    input wire PSLVERR, // APB error
    input wire TRIP, // Drive tripped
    input wire RUNNING, // Drive running
    input wire FRAME_VALID, // Frame strobe
    input wire [7:0] FRAME_ADDR, // Frame station
    input wire FRAME_ACCEPT, // Frame taken
    input wire FAULT_RELAY, // Fault relay
    input wire CLEAN_RELAY, // Clean relay
    input wire LINK_LOSS_FAULT, // Link loss fault
    input wire HOLD_ACTIVE, // Hold reaction
    input wire COAST_STOP, // Coast reaction
    input wire DECEL_STOP, // Decel reaction
    input wire [1:0] TEST_LEVEL // Test output code
);
    reg [7:0] station_r;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);

    // ----------------------------------------
    // Shadow of the station field
    // ----------------------------------------
    always @(posedge CLOCK) begin
        if (!RSTN) begin
            station_r <= 8'h01;
        end else if (PSEL && PENABLE && PWRITE && PADDR == 8'h10) begin
            station_r <= PWDATA[7:0];
        end
    end

    sequence access_ph;
        PSEL && PENABLE;
    endsequence
    sequence stopped3;
        !RUNNING [*3];
    endsequence

    a_unmapped_err: assert property (access_ph and PADDR >= 8'h20 |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    a_accept_match: assert property (FRAME_VALID && FRAME_ADDR == station_r |=> FRAME_ACCEPT)
        else $error("own frame not accepted");
    a_accept_cause: assert property (FRAME_ACCEPT |-> $past(FRAME_VALID) && $past(FRAME_ADDR) == station_r)
        else $error("foreign frame accepted");
    a_loss_flags: assert property (HOLD_ACTIVE || COAST_STOP || DECEL_STOP |-> LINK_LOSS_FAULT)
        else $error("reaction without loss fault");
    a_react_excl: assert property ($onehot0({HOLD_ACTIVE, COAST_STOP, DECEL_STOP}))
        else $error("two reactions at once");
    a_loss_clear: assert property (FRAME_ACCEPT |=> !LINK_LOSS_FAULT)
        else $error("loss fault survives own frame");
    a_trip_on: assert property ($rose(FAULT_RELAY) |-> $past(TRIP) == 1'b1)
        else $error("fault relay closed without trip");
    a_trip_off: assert property ($fell(FAULT_RELAY) |-> $past(TRIP) == 1'b0)
        else $error("fault relay opened during trip");
    a_clean_idle: assert property (stopped3 |-> !CLEAN_RELAY)
        else $error("clean relay closed while stopped");
    a_test_code: assert property (TEST_LEVEL != 2'h3)
        else $error("illegal test level");
endmodule // dios_props

bind dios_top dios_props u_props (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
    .TRIP(TRIP), .RUNNING(RUNNING), .FRAME_VALID(FRAME_VALID), .FRAME_ADDR(FRAME_ADDR),
    .FRAME_ACCEPT(FRAME_ACCEPT), .FAULT_RELAY(FAULT_RELAY), .CLEAN_RELAY(CLEAN_RELAY),
    .LINK_LOSS_FAULT(LINK_LOSS_FAULT), .HOLD_ACTIVE(HOLD_ACTIVE), .COAST_STOP(COAST_STOP),
    .DECEL_STOP(DECEL_STOP), .TEST_LEVEL(TEST_LEVEL));

// file: verification/tb_top.sv
// Self-checking bench for the drive supervision block
`timescale 1ns/100ps
`include "dios_defs.vh"
module tb_top;
    // One tick per cycle keeps a second at 1000 cycles
    localparam int SEC = 1000;
    logic CLOCK = 1'b0, RSTN = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00, TEMP_C = 8'h00, FRAME_ADDR;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic TRIP = 1'b0, RUNNING = 1'b0, FRAME_VALID, TX_REQ, FRAME_ACCEPT, TX_START, er, acc;
    logic [15:0] SPEED_IN = 16'h1234, SPEED_HOLD;
    logic [10:0] RAW_INPUTS = 11'h0a5, INPUTS, expin;
    logic PREADY, PSLVERR, FAULT_RELAY, FAN_ON, CLEAN_RELAY, LINK_LOSS_FAULT, HOLD_ACTIVE;
    logic COAST_STOP, DECEL_STOP, SECOND_SET, SECOND_GAIN;
    logic [1:0] TEST_LEVEL;
    logic [31:0] rst_val [6] = '{`DIOS_CTRL_RST, `DIOS_FLT_DLY_RST, `DIOS_FAN_TEMP_RST,
        `DIOS_CLEAN_RST, `DIOS_COMM_RST, 32'h0};
    int bad_count = 0, n_tests = 0, waited;

    always #2.5 CLOCK = ~CLOCK;

    dios_top #(.TICK_CYCLES(1)) dut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
        .PRDATA(PRDATA), .PSLVERR(PSLVERR), .TRIP(TRIP), .RUNNING(RUNNING), .TEMP_C(TEMP_C),
        .SPEED_IN(SPEED_IN), .RAW_INPUTS(RAW_INPUTS), .FRAME_VALID(FRAME_VALID),
        .FRAME_ADDR(FRAME_ADDR), .TX_REQ(TX_REQ), .FRAME_ACCEPT(FRAME_ACCEPT),
        .TX_START(TX_START), .FAULT_RELAY(FAULT_RELAY), .FAN_ON(FAN_ON),
        .CLEAN_RELAY(CLEAN_RELAY), .LINK_LOSS_FAULT(LINK_LOSS_FAULT),
        .HOLD_ACTIVE(HOLD_ACTIVE), .COAST_STOP(COAST_STOP), .DECEL_STOP(DECEL_STOP),
        .SPEED_HOLD(SPEED_HOLD), .TEST_LEVEL(TEST_LEVEL), .INPUTS(INPUTS),
        .SECOND_SET(SECOND_SET), .SECOND_GAIN(SECOND_GAIN));

    dios_net_master net (.clk(CLOCK), .frame_accept(FRAME_ACCEPT), .tx_start(TX_START),
        .frame_valid(FRAME_VALID), .frame_addr(FRAME_ADDR), .tx_req(TX_REQ));

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PADDR <= a;
        PWRITE <= w;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        @(posedge CLOCK);
        while (PREADY !== 1'b1) @(posedge CLOCK);
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Second-function input 3, second-gain input 4
    function automatic logic [31:0] ctrl(input int fan, react, src, tst);
        return 32'h0043_0000 | fan | (react << 2) | (src << 4) | (tst << 8) | 32'h200;
    endfunction

    task tally_and_finish;
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #(90000 * 5);
        bad_count = bad_count + 1;
        tally_and_finish;
    end

    initial begin
        repeat (12) @(posedge CLOCK);
        RSTN <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(8'(i * 4), 1'b0, 32'h0);
            check("reset value", rd, rst_val[i]);
        end
        apb(8'h20, 1'b0, 32'h0);
        check("unmapped", {rd[30:0], er}, 32'h1);
        check("fan power", FAN_ON, 1'b1);
        apb(8'h1c, 1'b1, 32'hffff);
        apb(8'h1c, 1'b0, 32'h0);
        check("hold read only", rd, 32'h0);
        for (int m = 1; m < 3; m++) begin
            apb(8'h00, 1'b1, ctrl(m, 0, 0, 0));
            repeat (4) @(posedge CLOCK);
            check("fan off", FAN_ON, 1'b0);
            RUNNING <= (m == 1);
            TEMP_C <= 8'd71;
            repeat (4) @(posedge CLOCK);
            check("fan on", FAN_ON, 1'b1);
            RUNNING <= 1'b0;
            TEMP_C <= 8'd70;
        end
        apb(8'h14, 1'b1, 32'h0000_0618);
        repeat (6) @(posedge CLOCK);
        expin = 11'h0a5 ^ 11'h618;
        check("inputs", INPUTS, expin);
        check("second set", SECOND_SET, expin[3]);
        check("second gain", SECOND_GAIN, expin[4]);
        RAW_INPUTS <= 11'h618;
        repeat (6) @(posedge CLOCK);
        check("inputs mask", INPUTS, 11'h000);
        apb(8'h10, 1'b1, 32'h0200_1421);
        net.send_frame(8'h22, acc);
        check("foreign frame", acc, 1'b0);
        net.send_frame(8'h21, acc);
        check("own frame", acc, 1'b1);
        net.ask_reply(waited);
        // 2 to 3 ms of wait, one cycle to register the pulse, one to see it
        check("reply delay", waited >= 4 && waited <= 5, 1'b1);
        apb(8'h04, 1'b1, 32'h0000_0002);
        TRIP <= 1'b1;
        repeat (900) @(posedge CLOCK);
        check("relay early", FAULT_RELAY, 1'b0);
        repeat (1200) @(posedge CLOCK);
        check("relay on", FAULT_RELAY, 1'b1);
        TRIP <= 1'b0;
        repeat (4) @(posedge CLOCK);
        check("relay off", FAULT_RELAY, 1'b0);
        RUNNING <= 1'b1;
        apb(8'h00, 1'b1, ctrl(0, 0, 0, 1));
        apb(8'h00, 1'b0, 32'h0);
        check("test self clear", rd[8], 1'b0);
        repeat (7 * SEC) @(posedge CLOCK);
        for (int k = 0; k < 4; k++) begin
            check("test level", TEST_LEVEL, (k % 2 == 0) ? `DIOS_LVL_3V : `DIOS_LVL_4V7);
            check("clean wait", CLEAN_RELAY, 1'b0);
            repeat (15 * SEC) @(posedge CLOCK);
        end
        check("test end", TEST_LEVEL, `DIOS_LVL_OFF);
        RUNNING <= 1'b0;
        SPEED_IN <= 16'h5678;
        for (int r = 0; r < 3; r++) begin
            apb(8'h00, 1'b1, ctrl(0, r, r + 1, 0));
            net.send_frame(8'h21, acc);
            repeat (15) @(posedge CLOCK);
            net.send_frame(8'h21, acc);
            repeat (15) @(posedge CLOCK);
            check("silence restart", LINK_LOSS_FAULT, 1'b0);
            repeat (15) @(posedge CLOCK);
            check("loss fault", LINK_LOSS_FAULT, 1'b1);
            check("reaction", {HOLD_ACTIVE, COAST_STOP, DECEL_STOP}, 3'b100 >> r);
            if (r == 0) check("held speed", SPEED_HOLD, 16'h1234);
        end
        apb(8'h00, 1'b1, ctrl(0, 1, 0, 0));
        net.send_frame(8'h21, acc);
        repeat (60) @(posedge CLOCK);
        check("no supervision", LINK_LOSS_FAULT, 1'b0);
        tally_and_finish;
    end
endmodule // tb_top
